// ### hdl/cgpd_defs.svh
// Offsets, field positions, reset values and sizes of the clock block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CGPD_DEFS_SVH
`define CGPD_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CGPD_PWRCTL_OFS    8'h00
`define CGPD_CLKSEL_OFS    8'h04
`define CGPD_CLKDIV_OFS    8'h08
`define CGPD_CLKGATE_OFS   8'h0C
`define CGPD_FDCTL_OFS     8'h10
`define CGPD_STATUS_OFS    8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CGPD_PWR_XTAL_BIT  0
`define CGPD_PWR_FRC_BIT   1
`define CGPD_PWR_LOWXT_BIT 2
`define CGPD_PWR_PDREQ_BIT 7
`define CGPD_FDEN_BIT      4

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define CGPD_PWRCTL_RST    8'h02
`define CGPD_CLKSEL_RST    2'h1
`define CGPD_CLKDIV_RST    4'h0
`define CGPD_CLKGATE_RST   8'h00
`define CGPD_FDCTL_RST     5'h00
`define CGPD_NUM_GATES     8
`define CGPD_NUM_STAGES    16
`define CGPD_NUM_OSC       3
`endif

// ### hdl/cgpd_pkg.sv
// Types shared by the clock block.
// Assumes nothing of its surroundings.
package cgpd_pkg;
    // Clock source codes of the source select field
    typedef enum logic [1:0] {
        SRC_XTAL = 2'h0,
        SRC_FRC  = 2'h1,
        SRC_SRC  = 2'h2,
        SRC_NONE = 2'h3
    } cgpd_src_t;

    // Power states
    typedef enum logic {
        PD_RUN  = 1'b0,
        PD_DOWN = 1'b1
    } cgpd_pwr_t;
endpackage

// ### hdl/cgpd_sync.sv
// Three-stage synchroniser with agreement filter and rise pulse.
// Assumes asynchronous inputs and a single system clock.
`timescale 1ns/1ps
module cgpd_sync #(
    parameter int W = 3
) (
    input  logic         aclk,
    input  logic         aresetn,
    input  logic [W-1:0] async_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_d;

    // Agreement of second and third stage moves the level
    assign lvl_d = (s2_q & s3_q) | (level & (s2_q | s3_q));

    // Synchroniser chain
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            level <= '0;
            rise  <= '0;
        end
        else
        begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            level <= lvl_d;
            rise  <= lvl_d & ~level;
        end
    end
endmodule

// ### hdl/cgpd_freq_div.sv
// Sixteen-stage power-of-two divider with stage selector.
// Assumes a one-cycle input tick and same-clock control.
`timescale 1ns/1ps
`include "cgpd_defs.svh"
module cgpd_freq_div (
    input  logic       aclk,
    input  logic       aresetn,
    input  logic       fin_tick,
    input  logic       enable,
    input  logic [3:0] stage_sel,
    output logic       div_out,
    output logic       running
);
    localparam int N = `CGPD_NUM_STAGES;
    logic [N-1:0] chain_q;
    logic [N:0]   carry;
    logic         en_prev_q;
    logic         en_rise;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Mask of stages below the selected one
    function automatic logic [N-1:0] low_mask(input logic [3:0] s);
        low_mask = (16'h0001 << s) - 16'h0001;
    endfunction

    assign en_rise  = enable & ~en_prev_q;
    assign carry[0] = fin_tick & running;

    // ----------------------------------------
    // Divide-by-two chain
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_stage
            assign carry[i+1] = carry[i] & chain_q[i];
            // One divide-by-two stage
            always_ff @(posedge aclk)
            begin
                if (!aresetn || en_rise)
                    chain_q[i] <= 1'b0;
                else if (carry[i])
                    chain_q[i] <= ~chain_q[i];
            end
        end
    endgenerate

    // Run control: start on enable edge, stop at low output
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_prev_q <= 1'b0;
            running   <= 1'b0;
        end
        else
        begin
            en_prev_q <= enable;
            if (en_rise)
                running <= 1'b1;
            else if (!enable && !chain_q[stage_sel])
                running <= 1'b0;
        end
    end

    // Selected stage to the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_out <= 1'b0;
        else
            div_out <= running & chain_q[stage_sel];
    end

    a_chain_restart: assert property (
        en_rise |=> chain_q == '0 && running)
        else $error("chain not restarted on enable rise");
    a_stage_carry: assert property (
        carry[0] && !en_rise |=> chain_q == $past(chain_q) + 16'h0001)
        else $error("chain did not advance by one");
    a_select_toggle: assert property (
        carry[0] && !en_rise
        && (chain_q & low_mask(stage_sel)) == low_mask(stage_sel)
        |=> chain_q[$past(stage_sel)] != $past(chain_q[stage_sel]))
        else $error("selected stage missed its toggle");
    a_pin_follows: assert property (
        running && $stable(stage_sel) ##1 running
        |-> div_out == $past(chain_q[stage_sel]))
        else $error("pin does not show selected stage");
    a_stop_low: assert property (
        !enable && running && !chain_q[stage_sel] && !en_rise
        |=> !running ##1 !div_out)
        else $error("divider did not stop low");
    a_keep_high: assert property (
        !enable && running && chain_q[stage_sel] |=> running)
        else $error("divider stopped while output high");
endmodule

// ### hdl/cgpd_top.sv
// Clock generator, gating, divider and power-down control.
// Assumes an AXI4-Lite master, a core that flags its wait-for-interrupt
// instruction and wake-ups with one-cycle pulses on aclk, and free
// running oscillator outputs arriving asynchronously.
//
// Operation
// - Enter power-down only when request bit is set and core waits
// - Stay powered down until a wake-up source fires, then leave
// - Power-down turns off crystal and fast internal oscillator
// - Three selectable sources: crystal, fast RC and slow RC
// - Per-clock gates, source select and a 4-bit clock divider
// - Divider is sixteen chained divide-by-two stages
// - Sixteen-to-one selector drives one stage onto the output pin
// - Output frequency is input over two to the select plus one
// - Rising divider enable resets the chain, then counting starts
// - Clearing enable runs chain until output low, then holds low
`timescale 1ns/1ps
`include "cgpd_defs.svh"
module cgpd_top (
    input  logic        aclk,
    input  logic        aresetn,
    input  logic        awvalid,
    output logic        awready,
    input  logic [7:0]  awaddr,
    input  logic        wvalid,
    output logic        wready,
    input  logic [31:0] wdata,
    input  logic [3:0]  wstrb,
    output logic        bvalid,
    input  logic        bready,
    output logic [1:0]  bresp,
    input  logic        arvalid,
    output logic        arready,
    input  logic [7:0]  araddr,
    output logic        rvalid,
    input  logic        rready,
    output logic [31:0] rdata,
    output logic [1:0]  rresp,
    input  logic        wait_for_interrupt_instruction,
    input  logic        wake_request,
    input  logic        crystal_osc_in,
    input  logic        fast_internal_rc_in,
    input  logic        slow_internal_rc_in,
    output logic        crystal_osc_enable,
    output logic        fast_internal_rc_enable,
    output logic        crystal_low_speed_mode,
    output logic        hclk_enable,
    output logic [7:0]  periph_clk_enable,
    output logic        divided_clock_output_pin,
    output logic        power_down_active
);
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam int         NG       = `CGPD_NUM_GATES;

    // Register state
    logic [7:0]  pwrctl_q;
    logic [1:0]  clksel_q;
    logic [3:0]  clkdiv_q;
    logic [7:0]  gate_q;
    logic [4:0]  fdiv_q;
    // Bus state
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_fire;
    logic [2:0]  wr_idx;
    logic        wr_ok;
    logic [31:0] rd_val;
    // Clocking state
    cgpd_pkg::cgpd_pwr_t state_q;
    cgpd_pkg::cgpd_pwr_t state_d;
    logic [2:0]  osc_rise;
    logic        src_tick;
    logic [3:0]  div_cnt_q;
    logic        hclk_d;
    logic        fdiv_running;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Map a byte address to a register index, 7 when unmapped
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            `CGPD_PWRCTL_OFS:  reg_index = 3'h0;
            `CGPD_CLKSEL_OFS:  reg_index = 3'h1;
            `CGPD_CLKDIV_OFS:  reg_index = 3'h2;
            `CGPD_CLKGATE_OFS: reg_index = 3'h3;
            `CGPD_FDCTL_OFS:   reg_index = 3'h4;
            `CGPD_STATUS_OFS:  reg_index = 3'h5;
            default:           reg_index = 3'h7;
        endcase
    endfunction

    // Merge write data into old value under byte strobes
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  be
    );
        merge = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                merge[b*8 +: 8] = nw[b*8 +: 8];
    endfunction

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    assign awready = !aw_have_q && !bvalid;
    assign wready  = !w_have_q && !bvalid;
    assign wr_fire = aw_have_q && w_have_q && !bvalid;
    assign wr_idx  = reg_index(awaddr_q);
    assign wr_ok   = wr_idx != 3'h7;

    // Address and data holding, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= awaddr;
            end
            else if (wr_fire)
                aw_have_q <= 1'b0;
            if (wvalid && wready)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            else if (wr_fire)
                w_have_q <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= RESP_OK;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? RESP_OK : RESP_ERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Software writes; wake clears the power-down request
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwrctl_q <= `CGPD_PWRCTL_RST;
            clksel_q <= `CGPD_CLKSEL_RST;
            clkdiv_q <= `CGPD_CLKDIV_RST;
            gate_q   <= `CGPD_CLKGATE_RST;
            fdiv_q   <= `CGPD_FDCTL_RST;
        end
        else if (wr_fire && wr_ok)
        begin
            case (wr_idx)
                3'h0: pwrctl_q <= 8'(merge({24'h0, pwrctl_q},
                                        wdata_q, wstrb_q));
                3'h1: clksel_q <= 2'(merge({30'h0, clksel_q},
                                        wdata_q, wstrb_q));
                3'h2: clkdiv_q <= 4'(merge({28'h0, clkdiv_q},
                                        wdata_q, wstrb_q));
                3'h3: gate_q   <= 8'(merge({24'h0, gate_q},
                                        wdata_q, wstrb_q));
                3'h4: fdiv_q   <= 5'(merge({27'h0, fdiv_q},
                                        wdata_q, wstrb_q));
                default: ;
            endcase
        end
        // Wake clears the request unless this register is written now
        if (aresetn && state_q == cgpd_pkg::PD_DOWN && wake_request
            && !(wr_fire && wr_idx == 3'h0))
            pwrctl_q[`CGPD_PWR_PDREQ_BIT] <= 1'b0;
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign arready = !rvalid;

    // Read multiplexer
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (reg_index(araddr))
            3'h0: rd_val[7:0] = pwrctl_q;
            3'h1: rd_val[1:0] = clksel_q;
            3'h2: rd_val[3:0] = clkdiv_q;
            3'h3: rd_val[7:0] = gate_q;
            3'h4: rd_val[4:0] = fdiv_q;
            3'h5: rd_val[2:0] = {divided_clock_output_pin,
                                 fdiv_running, power_down_active};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Read response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OK;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata  <= rd_val;
            rresp  <= reg_index(araddr) == 3'h7 ? RESP_ERR : RESP_OK;
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // ----------------------------------------
    // Power-down sequencing
    // ----------------------------------------
    // Next power state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            cgpd_pkg::PD_RUN:
                if (pwrctl_q[`CGPD_PWR_PDREQ_BIT]
                    && wait_for_interrupt_instruction)
                    state_d = cgpd_pkg::PD_DOWN;
            cgpd_pkg::PD_DOWN:
                if (wake_request)
                    state_d = cgpd_pkg::PD_RUN;
            default: state_d = cgpd_pkg::PD_RUN;
        endcase
    end

    // Power state and oscillator enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q                 <= cgpd_pkg::PD_RUN;
            crystal_osc_enable      <= 1'b0;
            fast_internal_rc_enable <= 1'b1;
            crystal_low_speed_mode  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            crystal_osc_enable <= pwrctl_q[`CGPD_PWR_XTAL_BIT]
                && state_d == cgpd_pkg::PD_RUN;
            fast_internal_rc_enable <= pwrctl_q[`CGPD_PWR_FRC_BIT]
                && state_d == cgpd_pkg::PD_RUN;
            crystal_low_speed_mode <= pwrctl_q[`CGPD_PWR_LOWXT_BIT];
        end
    end

    assign power_down_active = state_q == cgpd_pkg::PD_DOWN;

    // ----------------------------------------
    // Clock sources and divider
    // ----------------------------------------
    cgpd_sync #(
        .W(`CGPD_NUM_OSC)
    ) u_osc_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({slow_internal_rc_in, fast_internal_rc_in,
                    crystal_osc_in}),
        .level    (),
        .rise     (osc_rise)
    );

    // Source selection; no ticks while powered down
    always_comb
    begin
        src_tick = 1'b0;
        case (cgpd_pkg::cgpd_src_t'(clksel_q))
            cgpd_pkg::SRC_XTAL: src_tick = osc_rise[0];
            cgpd_pkg::SRC_FRC:  src_tick = osc_rise[1];
            cgpd_pkg::SRC_SRC:  src_tick = osc_rise[2];
            default:            src_tick = 1'b0;
        endcase
        if (state_q == cgpd_pkg::PD_DOWN)
            src_tick = 1'b0;
    end

    assign hclk_d = src_tick && div_cnt_q == clkdiv_q;

    // Divide source ticks by clock divider plus one
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt_q   <= 4'h0;
            hclk_enable <= 1'b0;
        end
        else
        begin
            hclk_enable <= hclk_d;
            if (hclk_d || div_cnt_q > clkdiv_q)
                div_cnt_q <= 4'h0;
            else if (src_tick)
                div_cnt_q <= div_cnt_q + 4'h1;
        end
    end

    // Per-peripheral clock gates
    genvar g;
    generate
        for (g = 0; g < NG; g++)
        begin : g_gate
            // One gated clock enable
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    periph_clk_enable[g] <= 1'b0;
                else
                    periph_clk_enable[g] <= hclk_d && gate_q[g];
            end
        end
    endgenerate

    cgpd_freq_div u_freq_div (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .fin_tick  (src_tick),
        .enable    (fdiv_q[`CGPD_FDEN_BIT]),
        .stage_sel (fdiv_q[3:0]),
        .div_out   (divided_clock_output_pin),
        .running   (fdiv_running)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_entry_req;
        state_q == cgpd_pkg::PD_RUN && pwrctl_q[`CGPD_PWR_PDREQ_BIT]
        && wait_for_interrupt_instruction;
    endsequence

    sequence s_down_wait;
        state_q == cgpd_pkg::PD_DOWN && !wake_request;
    endsequence

    a_pd_entry: assert property (
        s_entry_req |=> power_down_active && !crystal_osc_enable)
        else $error("power-down not entered");
    a_no_entry: assert property (
        state_q == cgpd_pkg::PD_RUN && !(pwrctl_q[`CGPD_PWR_PDREQ_BIT]
        && wait_for_interrupt_instruction) |=> !power_down_active)
        else $error("power-down entered without both causes");
    a_pd_hold: assert property (
        s_down_wait |=> power_down_active)
        else $error("left power-down without wake-up");
    a_pd_exit: assert property (
        power_down_active && wake_request && !wr_fire
        |=> !power_down_active && !pwrctl_q[`CGPD_PWR_PDREQ_BIT])
        else $error("wake-up did not leave power-down");
    a_osc_off: assert property (
        power_down_active
        |-> !crystal_osc_enable && !fast_internal_rc_enable)
        else $error("oscillator on in power-down");
    a_src_none: assert property (
        clksel_q == 2'h3 || power_down_active |-> !src_tick)
        else $error("tick from no selected source");
    a_gate_off: assert property (
        (periph_clk_enable & ~$past(gate_q)) == 8'h00)
        else $error("gated clock ran while off");
    a_div_hclk: assert property (
        hclk_enable && clkdiv_q == 4'h1 && $stable(clkdiv_q)
        |-> !$past(hclk_enable))
        else $error("clock divider by two gave adjacent ticks");
    a_reset_enable: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> !fdiv_q[`CGPD_FDEN_BIT] && !fdiv_running)
        else $error("divider enable not clear after reset");
endmodule

// ### tb/cgpd_core_model.sv
// Core-side model: AXI4-Lite master tasks, wait and wake pulses.
// Assumes the clock block answers on aclk; a hung wait raises timed_out.
`timescale 1ns/1ps
module cgpd_core_model (
    input  logic        aclk,
    output logic        awvalid,
    input  logic        awready,
    output logic [7:0]  awaddr,
    output logic        wvalid,
    input  logic        wready,
    output logic [31:0] wdata,
    output logic [3:0]  wstrb,
    input  logic        bvalid,
    output logic        bready,
    input  logic [1:0]  bresp,
    output logic        arvalid,
    input  logic        arready,
    output logic [7:0]  araddr,
    input  logic        rvalid,
    output logic        rready,
    input  logic [31:0] rdata,
    input  logic [1:0]  rresp,
    output logic        nap,
    output logic        wake,
    output logic        timed_out
);
    // Idle bus at time zero
    initial
    begin
        {awvalid, wvalid, arvalid, bready, rready} = 5'h00;
        {nap, wake, timed_out} = 3'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
    end

    // Write: address and data together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready)
            begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        timed_out <= 1'b1;
    endtask

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
            begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        timed_out <= 1'b1;
    endtask

    // One-cycle wait (sel 0) or wake (sel 1) pulse
    task automatic pulse(input bit sel);
        @(posedge aclk);
        if (sel) wake <= 1'b1;
        else nap <= 1'b1;
        @(posedge aclk);
        wake <= 1'b0;
        nap <= 1'b0;
    endtask
endmodule

// ### tb/clock_gen_power_down_divider_bench.sv
// Bench for the clock block: registers, sources, power-down, divider.
// Assumes the core model in cgpd_core_model and slow oscillators.
`timescale 1ns/1ps
module clock_gen_power_down_divider_bench;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0]  r;
    } cgpd_row_t;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, nap, wake, tmo;
    logic [7:0] awaddr, araddr, periph_clk_enable, pm;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic xtal, frc, lrc, crystal_osc_enable, fast_internal_rc_enable;
    logic crystal_low_speed_mode, hclk_enable, pin, power_down_active;
    int err_count, n_checks, c, hi;
    cgpd_row_t rows[6] = '{'{8'h00, 32'h83, 32'h83, 2'h0},
        '{8'h04, 32'h2, 32'h2, 2'h0}, '{8'h08, 32'hFFFFFFFF, 32'hF, 2'h0},
        '{8'h08, 32'h1, 32'h1, 2'h0}, '{8'h0C, 32'hA5, 32'hA5, 2'h0},
        '{8'h20, 32'h1234, 32'h0, 2'h2}};

    cgpd_top cgpd_top_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .wait_for_interrupt_instruction(nap), .wake_request(wake),
        .crystal_osc_in(xtal), .fast_internal_rc_in(frc),
        .slow_internal_rc_in(lrc), .crystal_osc_enable,
        .fast_internal_rc_enable, .crystal_low_speed_mode, .hclk_enable,
        .periph_clk_enable, .divided_clock_output_pin(pin),
        .power_down_active);
    cgpd_core_model cgpd_core_model_inst (.aclk, .awvalid, .awready,
        .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
        .rresp, .nap, .wake, .timed_out(tmo));

    // Clock and oscillators; gated sources stop while disabled
    initial
    begin
        {aclk, xtal, frc, lrc} = 4'h0;
        forever #12.5 aclk = ~aclk;
    end
    always #200 xtal = (crystal_osc_enable === 1'b1) ? ~xtal : 1'b0;
    always #250 frc = (fast_internal_rc_enable === 1'b1) ? ~frc : 1'b0;
    always #1000 lrc = ~lrc;
    always @(posedge tmo)
    begin
        err_count++;
        wrap_up();
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Cycles to the next rising edge of the divided pin
    task automatic wait_rise(output int n);
        logic p;
        p = pin;
        for (n = 1; n < 3000; n++)
        begin
            @(posedge aclk);
            if (pin === 1'b1 && p === 1'b0) return;
            p = pin;
        end
        err_count++;
        wrap_up();
    endtask

    // Main sequence
    initial
    begin
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk("pin_rst", pin, 0);
        chk("pd_rst", power_down_active, 0);
        cgpd_core_model_inst.rd(8'h10, got, rsp);
        chk("fdiv_rst", got, 0);
        foreach (rows[i])
        begin
            cgpd_core_model_inst.wr(rows[i].a, rows[i].d, rsp);
            chk("bresp", 32'(rsp), 32'(rows[i].r));
            cgpd_core_model_inst.rd(rows[i].a, got, rsp);
            chk("rdata", got, rows[i].q);
            chk("rresp", 32'(rsp), 32'(rows[i].r));
        end
        // Every source code, gates masking the unset bits
        cgpd_core_model_inst.wr(8'h00, 32'h03, rsp);
        for (int s = 0; s < 4; s++)
        begin
            cgpd_core_model_inst.wr(8'h04, s, rsp);
            c = 0;
            pm = 8'h00;
            repeat (400)
            begin
                @(posedge aclk);
                if (hclk_enable === 1'b1) c++;
                pm = pm | periph_clk_enable;
            end
            chk("src_ticks", 32'(c > 0), 32'(s < 3));
            chk("gated", 32'(pm), s < 3 ? 32'hA5 : 0);
        end
        // Power-down entry needs both request bit and wait
        cgpd_core_model_inst.pulse(0);
        #1 chk("pd_wfi_only", power_down_active, 0);
        cgpd_core_model_inst.wr(8'h00, 32'h87, rsp);
        repeat (5) @(posedge aclk);
        #1 chk("pd_req_only", power_down_active, 0);
        cgpd_core_model_inst.pulse(0);
        #1 chk("pd_entry", power_down_active, 1);
        chk("xtal_off", crystal_osc_enable, 0);
        chk("frc_off", fast_internal_rc_enable, 0);
        repeat (8) @(posedge aclk);
        #1 chk("pd_stay", power_down_active, 1);
        cgpd_core_model_inst.pulse(1);
        #1 chk("pd_exit", power_down_active, 0);
        chk("xtal_on", crystal_osc_enable, 1);
        chk("frc_on", fast_internal_rc_enable, 1);
        chk("low_xt", crystal_low_speed_mode, 1);
        cgpd_core_model_inst.rd(8'h00, got, rsp);
        chk("req_clear", got, 32'h07);
        // Divider on the fast RC: one tick every 20 cycles
        cgpd_core_model_inst.wr(8'h04, 32'h1, rsp);
        for (int n = 0; n < 4; n++)
        begin
            cgpd_core_model_inst.wr(8'h10, 32'h10 | n, rsp);
            wait_rise(c);
            chk("first_rise", 32'(c > (20 << n) - 25 && c < (20 << n) + 30),
                1);
            wait_rise(c);
            chk("period", c, 40 << n);
            cgpd_core_model_inst.wr(8'h10, n, rsp);
            repeat ((20 << n) + 40) @(posedge aclk);
            hi = 0;
            repeat (40 << n)
            begin
                @(posedge aclk);
                if (pin !== 1'b0) hi++;
            end
            chk("held_low", hi, 0);
            cgpd_core_model_inst.rd(8'h14, got, rsp);
            chk("stopped", got & 32'h6, 0);
        end
        wrap_up();
    end
endmodule
